//--- hw/adc_serial_dev.sv
`timescale 1ns/1ns
module adc_serial_dev #(
  parameter int unsigned OSC_CYCLES = adc_serial_pkg::OSC_CYC,
  parameter int unsigned PERIOD_SHIFT = 0,
  parameter logic [23:0] FS_RESET = adc_serial_pkg::FS_RST_DEFAULT,
  // Identity value is arbitrary
  parameter logic [7:0] ID_VALUE = 8'h3C
) (
  // Serial link
  adc_link_if.device link,
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Converter side
  input wire logic [19:0] sample_in,
  output logic conv_done,
  output adc_serial_pkg::filter_t filter_sel,
  output logic power_down
);
  import adc_serial_pkg::*;

  typedef enum logic [1:0] {
    PH_CMD = 2'b00,
    PH_WR = 2'b01,
    PH_RD = 2'b10,
    PH_CR = 2'b11
  } phase_t;

  typedef enum logic [1:0] {
    CV_START = 2'b00,
    CV_OSC = 2'b01,
    CV_RUN = 2'b10,
    CV_STOP = 2'b11
  } conv_t;

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic sck_s1;
    logic sck_s2;
    logic sck_d;
    logic din_s1;
    logic din_s2;
    phase_t phase;
    logic [4:0] bitcnt;
    logic [4:0] len;
    logic [2:0] rs;
    logic cread;
    logic [5:0] ones;
    logic [23:0] sin;
    logic [23:0] sout;
    logic [15:0] mode_r;
    logic [15:0] conf_r;
    logic [7:0] io_r;
    logic [23:0] offs_r;
    logic [23:0] fs_r;
    logic [23:0] data_r;
    logic rdy_n;
    logic dout;
    logic dout_oe;
    conv_t conv;
    logic [31:0] tmr;
    logic nconv;
    logic conv_done;
    filter_t filter_sel;
    logic power_down;
  } state_t;

  localparam state_t ST_RST = '{
    cs_s1: 1'b1, cs_s2: 1'b1, sck_s1: 1'b1, sck_s2: 1'b1, sck_d: 1'b1,
    din_s1: 1'b0, din_s2: 1'b0, phase: PH_CMD, bitcnt: 5'h00,
    len: 5'h08, rs: RS_COMM, cread: 1'b0, ones: 6'h00, sin: 24'h000000,
    sout: 24'h000000, mode_r: MODE_RST, conf_r: CONF_RST, io_r: IO_RST,
    offs_r: OFFS_RST, fs_r: FS_RESET, data_r: 24'h000000, rdy_n: 1'b1,
    dout: 1'b1, dout_oe: 1'b0, conv: CV_START, tmr: 32'h00000000,
    nconv: 1'b0, conv_done: 1'b0, filter_sel: FILT_SINC3_MOD,
    power_down: 1'b0
  };

  state_t s;
  state_t n;
  logic rise;
  logic [4:0] cnt1;
  logic [7:0] cmd;
  logic [2:0] cmd_rs;
  logic [23:0] rd_val;
  logic [23:0] word;
  logic [31:0] period;
  logic [2:0] md;
  logic mode_wr;
  logic complete;
  logic last;

  always_comb begin
    n = s;
    n.conv_done = 1'b0;
    // Edges while deselected are ignored
    rise = s.sck_s2 & ~s.sck_d & ~s.cs_s2;
    cnt1 = s.bitcnt + 5'd1;
    cmd = {s.sin[6:0], s.din_s2};
    cmd_rs = cmd[CMD_RS_LSB +: 3];
    word = {sample_in, RESULT_PAD};
    period = period_of(s.mode_r[MODE_FS_LSB +: 4]) >> PERIOD_SHIFT;
    md = s.mode_r[MODE_MD_LSB +: 3];
    mode_wr = 1'b0;
    complete = 1'b0;
    last = (md != MD_SINGLE) || s.nconv;
    case (cmd_rs)
      RS_COMM: rd_val = {s.rdy_n, 7'h00, 16'h0000};
      RS_MODE: rd_val = {s.mode_r, 8'h00};
      RS_CONF: rd_val = {s.conf_r, 8'h00};
      RS_DATA: rd_val = s.data_r;
      RS_ID: rd_val = {ID_VALUE, 16'h0000};
      RS_IO: rd_val = {s.io_r, 16'h0000};
      RS_OFFS: rd_val = s.offs_r;
      default: rd_val = s.fs_r;
    endcase

    // Serial side: sample on rising edge, shift out after it
    if (rise) begin
      n.sin = {s.sin[22:0], s.din_s2};
      n.bitcnt = cnt1;
      if (!s.din_s2) begin
        n.ones = 6'h00;
      end else if (s.ones != 6'(ONES_RESET)) begin
        n.ones = s.ones + 6'd1;
      end
      case (s.phase)
        PH_CMD: begin
          if (cnt1 == 5'(CMD_BITS)) begin
            n.bitcnt = 5'h00;
            // Byte taken as a command write
            if (!cmd[CMD_WEN_BIT]) begin
              n.rs = cmd_rs;
              n.len = reg_len(cmd_rs);
              if (cmd[CMD_RW_BIT]) begin
                n.sout = rd_val;
                n.phase = PH_RD;
                if (cmd_rs == RS_DATA && cmd[CMD_CREAD_BIT]) begin
                  n.cread = 1'b1;
                  n.phase = s.rdy_n ? PH_CMD : PH_CR;
                end
              end else if (cmd_rs != RS_COMM) begin
                n.phase = PH_WR;
              end
            end
          end
        end
        PH_WR: begin
          if (cnt1 == s.len) begin
            n.bitcnt = 5'h00;
            n.phase = PH_CMD;
            case (s.rs)
              RS_MODE: begin
                n.mode_r = n.sin[15:0];
                mode_wr = 1'b1;
              end
              RS_CONF: n.conf_r = n.sin[15:0];
              RS_IO: n.io_r = n.sin[7:0];
              RS_OFFS: n.offs_r = n.sin;
              RS_FS: n.fs_r = n.sin;
              default: n.phase = PH_CMD;
            endcase
          end
        end
        PH_RD: begin
          n.sout = {s.sout[22:0], 1'b1};
          if (cnt1 == s.len) begin
            n.bitcnt = 5'h00;
            n.phase = PH_CMD;
            if (s.rs == RS_DATA) begin
              n.rdy_n = 1'b1;
            end
          end
        end
        PH_CR: begin
          n.sout = {s.sout[22:0], 1'b1};
          // Data-in watched while the word goes out
          if (cnt1 == 5'(CMD_BITS) && cmd == CMD_CREAD_EXIT) begin
            n.cread = 1'b0;
            n.bitcnt = 5'h00;
            n.phase = PH_CMD;
          end else if (cnt1 == 5'(CREAD_BITS)) begin
            n.bitcnt = 5'h00;
            n.phase = PH_CMD;
            n.rdy_n = 1'b1;
          end
        end
        default: n.phase = PH_CMD;
      endcase
    end

    // Conversion timing
    case (s.conv)
      CV_START: begin
        n.tmr = period;
        n.nconv = 1'b0;
        n.conv = CV_RUN;
      end
      CV_OSC: begin
        if (s.tmr == 32'h00000000) begin
          n.tmr = period;
          n.conv = CV_RUN;
        end else begin
          n.tmr = s.tmr - 32'd1;
        end
      end
      CV_RUN: begin
        if (s.tmr == 32'd1 && last) begin
          n.rdy_n = 1'b1;
        end
        if (s.tmr == 32'h00000000) begin
          n.tmr = period;
          n.nconv = 1'b1;
          complete = last;
          if (last && md == MD_SINGLE) begin
            n.mode_r[MODE_MD_LSB +: 3] = MD_PDOWN;
            n.conv = CV_STOP;
          end
        end else begin
          n.tmr = s.tmr - 32'd1;
        end
      end
      default: n.conv = CV_STOP;
    endcase

    // A result is dropped while a command read of the data register (PH_RD) is under way
    if (complete) begin
      n.conv_done = 1'b1;
      if (!(s.phase == PH_RD && s.rs == RS_DATA)) begin
        n.data_r = word;
        n.rdy_n = 1'b0;
        if (s.cread) begin
          n.sout = word;
          n.bitcnt = 5'h00;
          n.phase = PH_CR;
        end
      end
    end

    if (mode_wr) begin
      case (n.mode_r[MODE_MD_LSB +: 3])
        MD_CONT: n.conv = CV_START;
        MD_SINGLE: begin
          n.conv = CV_OSC;
          n.tmr = 32'(OSC_CYCLES);
          n.nconv = 1'b0;
        end
        default: n.conv = CV_STOP;
      endcase
    end

    if (n.ones == 6'(ONES_RESET)) begin
      n = ST_RST;
    end

    n.cs_s1 = link.cs_n;
    n.cs_s2 = s.cs_s1;
    n.sck_s1 = link.sclk;
    n.sck_s2 = s.sck_s1;
    n.sck_d = s.sck_s2;
    n.din_s1 = link.din;
    n.din_s2 = s.din_s1;
    n.filter_sel = filter_of(n.mode_r[MODE_FS_LSB +: 4]);
    n.power_down = n.mode_r[MODE_MD_LSB +: 3] == MD_PDOWN;
    // Line driven from the third clock after select falls; MSB stands in read phases, ready flag otherwise
    // Only the second stage of the select synchroniser is read
    n.dout_oe = ~s.cs_s2;
    if (n.phase == PH_RD || n.phase == PH_CR) begin
      n.dout = n.sout[23];
    end else begin
      n.dout = n.rdy_n;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= ST_RST;
    end else begin
      s <= n;
    end
  end

  assign link.dout = s.dout;
  assign link.dout_oe = s.dout_oe;
  assign conv_done = s.conv_done;
  assign filter_sel = s.filter_sel;
  assign power_down = s.power_down;
endmodule

//--- hw/adc_serial_pkg.sv
package adc_serial_pkg;
  localparam int CLK_HZ = 50000000;
  localparam longint CLK_CHZ = 64'(CLK_HZ) * 64'd100;
  localparam int OSC_TIME_US = 1000;
  localparam int OSC_CYC = CLK_HZ / 1000000 * OSC_TIME_US;
  localparam int RST_WAIT_US = 500;
  localparam int RST_WAIT_CYC = CLK_HZ / 1000000 * RST_WAIT_US;
  localparam int SCLK_HALF = 8;
  localparam int ONES_RESET = 32;
  localparam int CREAD_BITS = 24;
  localparam int CMD_BITS = 8;

  localparam logic [2:0] RS_COMM = 3'h0;
  localparam logic [2:0] RS_MODE = 3'h1;
  localparam logic [2:0] RS_CONF = 3'h2;
  localparam logic [2:0] RS_DATA = 3'h3;
  localparam logic [2:0] RS_ID = 3'h4;
  localparam logic [2:0] RS_IO = 3'h5;
  localparam logic [2:0] RS_OFFS = 3'h6;
  localparam logic [2:0] RS_FS = 3'h7;

  localparam int CMD_WEN_BIT = 7;
  localparam int CMD_RW_BIT = 6;
  localparam int CMD_RS_LSB = 3;
  localparam int CMD_CREAD_BIT = 2;
  localparam logic [7:0] CMD_CREAD_ENTER = 8'h5C;
  localparam logic [7:0] CMD_CREAD_EXIT = 8'h58;

  localparam int MODE_MD_LSB = 13;
  localparam int MODE_FS_LSB = 0;
  localparam logic [2:0] MD_CONT = 3'h0;
  localparam logic [2:0] MD_SINGLE = 3'h1;
  localparam logic [2:0] MD_IDLE = 3'h2;
  localparam logic [2:0] MD_PDOWN = 3'h3;

  localparam logic [15:0] MODE_RST = 16'h000A;
  localparam logic [15:0] CONF_RST = 16'h0000;
  localparam logic [7:0] IO_RST = 8'h00;
  localparam logic [23:0] OFFS_RST = 24'h800000;
  localparam logic [23:0] FS_RST_DEFAULT = 24'h500000;
  localparam logic [3:0] RESULT_PAD = 4'hF;

  typedef enum logic [1:0] {
    FILT_SINC3_AVG = 2'b00,
    FILT_SINC3_MOD = 2'b01,
    FILT_SINC4 = 2'b10,
    FILT_INTEG = 2'b11
  } filter_t;

  function automatic logic [4:0] reg_len(input logic [2:0] rs);
    case (rs)
      RS_MODE, RS_CONF: reg_len = 5'd16;
      RS_DATA, RS_OFFS, RS_FS: reg_len = 5'd24;
      default: reg_len = 5'd8;
    endcase
  endfunction

  function automatic filter_t filter_of(input logic [3:0] fs);
    if (fs == 4'h1) begin
      filter_of = FILT_INTEG;
    end else if (fs >= 4'h2 && fs <= 4'h5) begin
      filter_of = FILT_SINC4;
    end else if (fs >= 4'hB) begin
      filter_of = FILT_SINC3_AVG;
    end else begin
      filter_of = FILT_SINC3_MOD;
    end
  endfunction

  // Update period in system clocks, rates held in hundredths of a hertz
  function automatic logic [31:0] period_of(input logic [3:0] fs);
    case (fs)
      4'h1: period_of = 32'(CLK_CHZ / 64'd47000);
      4'h2: period_of = 32'(CLK_CHZ / 64'd24200);
      4'h3: period_of = 32'(CLK_CHZ / 64'd12300);
      4'h4: period_of = 32'(CLK_CHZ / 64'd6200);
      4'h5: period_of = 32'(CLK_CHZ / 64'd5000);
      4'h6: period_of = 32'(CLK_CHZ / 64'd3900);
      4'h7: period_of = 32'(CLK_CHZ / 64'd3320);
      4'h8: period_of = 32'(CLK_CHZ / 64'd1960);
      4'hB: period_of = 32'(CLK_CHZ / 64'd1250);
      4'hC: period_of = 32'(CLK_CHZ / 64'd1000);
      4'hD: period_of = 32'(CLK_CHZ / 64'd833);
      4'hE: period_of = 32'(CLK_CHZ / 64'd625);
      4'hF: period_of = 32'(CLK_CHZ / 64'd417);
      default: period_of = 32'(CLK_CHZ / 64'd1670);
    endcase
  endfunction
endpackage

//--- hw/adc_link_if.sv
`timescale 1ns/1ns
interface adc_link_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe;
  logic miso;

  // Shared data-out line is pulled up while released
  assign miso = dout_oe ? dout : 1'b1;

  modport device (
    input cs_n,
    input sclk,
    input din,
    output dout,
    output dout_oe
  );
  modport host (
    output cs_n,
    output sclk,
    output din,
    input miso
  );
endinterface

//--- hw/adc_serial_host.sv
`timescale 1ns/1ns
module adc_serial_host #(
  parameter int unsigned RESET_WAIT = adc_serial_pkg::RST_WAIT_CYC
) (
  // Serial link
  adc_link_if.host link,
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Command port
  input wire logic req,
  input wire logic req_reset,
  input wire logic [5:0] req_bits,
  input wire logic [31:0] req_tx,
  input wire logic three_wire,
  output logic ready,
  output logic done,
  output logic [31:0] rx,
  output logic rdy_n
);
  import adc_serial_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_SHIFT = 2'b01,
    H_END = 2'b10,
    H_WAIT = 2'b11
  } hph_t;

  typedef struct packed {
    hph_t ph;
    logic [3:0] div;
    logic sclk;
    logic cs_n;
    logic din;
    logic [5:0] bits;
    logic [5:0] cnt;
    logic rst_op;
    logic [31:0] tx;
    logic [31:0] rx;
    logic [31:0] wait_cnt;
    logic done;
    logic ready;
    logic miso_s1;
    logic miso_s2;
    logic rdy_n;
  } hstate_t;

  localparam hstate_t HS_RST = '{
    ph: H_IDLE, div: 4'h0, sclk: 1'b1, cs_n: 1'b1, din: 1'b0,
    bits: 6'h00, cnt: 6'h00, rst_op: 1'b0, tx: 32'h00000000,
    rx: 32'h00000000, wait_cnt: 32'h00000000, done: 1'b0, ready: 1'b0,
    miso_s1: 1'b1, miso_s2: 1'b1, rdy_n: 1'b1
  };

  hstate_t s;
  hstate_t n;
  logic half;

  always_comb begin
    n = s;
    n.done = 1'b0;
    half = s.div == 4'(SCLK_HALF - 1);
    case (s.ph)
      H_IDLE: begin
        n.sclk = 1'b1;
        n.din = 1'b0;
        n.cs_n = ~three_wire;
        n.div = 4'h0;
        n.cnt = 6'h00;
        if (req_reset || req) begin
          n.rst_op = req_reset;
          n.tx = req_reset ? 32'hFFFFFFFF : req_tx;
          n.bits = req_reset ? 6'(ONES_RESET) : req_bits;
          n.cs_n = 1'b0;
          n.ph = H_SHIFT;
        end
      end
      H_SHIFT: begin
        n.div = half ? 4'h0 : s.div + 4'd1;
        if (half && s.sclk) begin
          n.sclk = 1'b0;
          n.din = s.tx[31];
        end else if (half) begin
          n.sclk = 1'b1;
          n.rx = {s.rx[30:0], s.miso_s2};
          n.tx = {s.tx[30:0], 1'b0};
          n.cnt = s.cnt + 6'd1;
          if (s.cnt + 6'd1 == s.bits) begin
            n.ph = H_END;
          end
        end
      end
      H_END: begin
        // Select held past the last edge so the device sees it selected
        n.div = s.div + 4'd1;
        if (half) begin
          n.din = 1'b0;
          n.cs_n = ~three_wire;
          n.wait_cnt = 32'(RESET_WAIT);
          n.ph = s.rst_op ? H_WAIT : H_IDLE;
          n.done = ~s.rst_op;
        end
      end
      default: begin
        n.din = 1'b0;
        if (s.wait_cnt == 32'h00000000) begin
          n.done = 1'b1;
          n.ph = H_IDLE;
        end else begin
          n.wait_cnt = s.wait_cnt - 32'd1;
        end
      end
    endcase
    n.miso_s1 = link.miso;
    n.miso_s2 = s.miso_s1;
    n.rdy_n = s.miso_s2;
    n.ready = (n.ph == H_IDLE) && !req && !req_reset;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= HS_RST;
    end else begin
      s <= n;
    end
  end

  assign link.cs_n = s.cs_n;
  assign link.sclk = s.sclk;
  assign link.din = s.din;
  assign ready = s.ready;
  assign done = s.done;
  assign rx = s.rx;
  assign rdy_n = s.rdy_n;
endmodule

//--- verification/adc_serial_conversion_ctrl_assertions.sv
`timescale 1ns/1ns
module adc_serial_conversion_ctrl_assertions (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic miso
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  property p_release;
    cs_n [*5] |-> !dout_oe && miso;
  endproperty
  a_release: assert property (p_release)
    else $error("data line driven while deselected");

  property p_idle_high;
    cs_n |-> sclk;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("serial clock low while deselected");

  property p_high_phase;
    $changed(sclk) |=> $stable(sclk) [*7];
  endproperty
  a_high_phase: assert property (p_high_phase)
    else $error("serial clock phase shorter than eight cycles");

  property p_din_hold;
    !cs_n && $rose(sclk) |=> $stable(din) [*7];
  endproperty
  a_din_hold: assert property (p_din_hold)
    else $error("data in moved while clock high");

  property p_frame_drive;
    $fell(cs_n) |-> ##[1:5] dout_oe;
  endproperty
  a_frame_drive: assert property (p_frame_drive)
    else $error("no drive after select fell");

  property p_clock_in_frame;
    $fell(sclk) |-> !cs_n;
  endproperty
  a_clock_in_frame: assert property (p_clock_in_frame)
    else $error("clock pulse outside a frame");

  property p_low_phase;
    $fell(sclk) |=> (!sclk) [*7] ##1 sclk;
  endproperty
  a_low_phase: assert property (p_low_phase)
    else $error("serial clock low phase not eight cycles");

  property p_selected_drive;
    (!cs_n && !din) [*6] |-> dout_oe;
  endproperty
  a_selected_drive: assert property (p_selected_drive)
    else $error("selected device not driving its line");

  c_ready_low: cover property (dout_oe && !dout);
endmodule

//--- verification/adc_serial_conversion_ctrl_tb_top.sv
`timescale 1ns/1ns
module adc_serial_conversion_ctrl_tb_top;
  import adc_serial_pkg::*;
  localparam int PER = int'((CLK_CHZ / 64'd1670) >> 10);
  localparam int OSC = 50;
  // Identity value is arbitrary
  localparam logic [7:0] ID_VAL = 8'hA5;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [19:0] sample_in = 20'h0;
  logic conv_done;
  filter_t filter_sel;
  logic power_down;
  logic req = 1'b0;
  logic req_reset = 1'b0;
  logic [5:0] req_bits = 6'h0;
  logic [31:0] req_tx = 32'h0;
  logic three_wire = 1'b0;
  logic ready, done, rdy_n;
  logic [31:0] rx;
  int err_total = 0;
  int tests_run = 0;

  always #10 clk_sys = ~clk_sys;

  adc_link_if adc_link_if_i ();
  adc_serial_dev #(.OSC_CYCLES(OSC), .PERIOD_SHIFT(10), .ID_VALUE(ID_VAL))
    adc_serial_dev_i (.link(adc_link_if_i), .clk_sys(clk_sys), .rst(rst),
    .sample_in(sample_in), .conv_done(conv_done), .filter_sel(filter_sel),
    .power_down(power_down));
  // Short reset wait keeps the run brief
  adc_serial_host #(.RESET_WAIT(20)) adc_serial_host_i (
    .link(adc_link_if_i), .clk_sys(clk_sys), .rst(rst), .req(req),
    .req_reset(req_reset), .req_bits(req_bits), .req_tx(req_tx),
    .three_wire(three_wire), .ready(ready), .done(done), .rx(rx),
    .rdy_n(rdy_n));
  adc_serial_conversion_ctrl_assertions adc_serial_conversion_ctrl_assertions_i (
    .clk_sys(clk_sys), .rst(rst), .cs_n(adc_link_if_i.cs_n),
    .sclk(adc_link_if_i.sclk), .din(adc_link_if_i.din),
    .dout(adc_link_if_i.dout), .dout_oe(adc_link_if_i.dout_oe),
    .miso(adc_link_if_i.miso));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic rr, input int bits, input logic [31:0] tx);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (ready !== 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    req = !rr;
    req_reset = rr;
    req_bits = 6'(bits);
    req_tx = tx;
    @(negedge clk_sys);
    req = 1'b0;
    req_reset = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    if (done !== 1'b1) begin
      err_total++;
      $display("unexpected at %0t: transfer never finished", $time);
    end
  endtask

  task automatic rd(input logic [2:0] rs, input int len, output logic [31:0] v);
    xfer(1'b0, 8 + len, {2'b01, rs, 3'b000, 24'h0});
    v = rx & ((32'h1 << len) - 32'h1);
  endtask

  task automatic wr(input logic [2:0] rs, input int len, input logic [23:0] v);
    logic [23:0] sh;
    sh = v << (24 - len);
    xfer(1'b0, 8 + len, {2'b00, rs, 3'b000, sh});
  endtask

  task automatic wait_conv(input int lim);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (conv_done !== 1'b1 && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    if (conv_done !== 1'b1) begin
      err_total++;
      $display("unexpected at %0t: no conversion", $time);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    logic [31:0] v;
    logic [2:0] rsl [6];
    int lens [6];
    logic [31:0] exps [6];
    logic [3:0] codes [7];
    filter_t fexp [7];
    int cnt;
    rsl = '{RS_MODE, RS_CONF, RS_ID, RS_IO, RS_OFFS, RS_FS};
    lens = '{16, 16, 8, 8, 24, 24};
    exps = '{32'(MODE_RST), 32'(CONF_RST), 32'(ID_VAL), 32'(IO_RST),
      32'(OFFS_RST), 32'(FS_RST_DEFAULT)};
    codes = '{4'h1, 4'h2, 4'h5, 4'h6, 4'h8, 4'hB, 4'hF};
    fexp = '{FILT_INTEG, FILT_SINC4, FILT_SINC4, FILT_SINC3_MOD,
      FILT_SINC3_MOD, FILT_SINC3_AVG, FILT_SINC3_AVG};
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(rsl[i], lens[i], v);
      chk(v, exps[i]);
    end
    $display("test register defaults finished");
    wr(RS_IO, 8, 24'h5A);
    // Top bit set: the byte is dropped, the zero byte after is harmless
    xfer(1'b0, 16, {8'hA8, 24'h0});
    rd(RS_IO, 8, v);
    chk(v, 32'h5A);
    $display("test write and refused command finished");
    sample_in = 20'hABCDE;
    wait_conv(4000);
    rd(RS_COMM, 8, v);
    chk(v, 32'h0);
    rd(RS_DATA, 24, v);
    chk(v, {8'h0, 20'hABCDE, RESULT_PAD});
    rd(RS_DATA, 24, v);
    chk(v, {8'h0, 20'hABCDE, RESULT_PAD});
    rd(RS_COMM, 8, v);
    chk(v, 32'h80);
    chk(32'(adc_link_if_i.miso), 32'h1);
    $display("test continuous conversion finished");
    three_wire = 1'b1;
    wait_conv(4000);
    repeat (8) @(negedge clk_sys);
    chk(32'(rdy_n), 32'h0);
    rd(RS_DATA, 24, v);
    repeat (8) @(negedge clk_sys);
    chk(32'(rdy_n), 32'h1);
    three_wire = 1'b0;
    $display("test three wire finished");
    // Mode is still continuous here
    xfer(1'b0, 8, {CMD_CREAD_ENTER, 24'h0});
    wait_conv(4000);
    xfer(1'b0, 24, 32'h0);
    chk(rx & 32'hFFFFFF, {8'h0, 20'hABCDE, RESULT_PAD});
    sample_in = 20'h12345;
    wait_conv(4000);
    sample_in = 20'h6789A;
    wait_conv(4000);
    xfer(1'b0, 24, 32'h0);
    chk(rx & 32'hFFFFFF, {8'h0, 20'h6789A, RESULT_PAD});
    wait_conv(4000);
    xfer(1'b0, 8, {CMD_CREAD_EXIT, 24'h0});
    rd(RS_MODE, 16, v);
    chk(v, 32'(MODE_RST));
    $display("test continuous read finished");
    for (int i = 0; i < 7; i++) begin
      wr(RS_MODE, 16, {8'h0, MD_PDOWN, 9'h0, codes[i]});
      repeat (4) @(negedge clk_sys);
      chk({30'h0, filter_sel}, {30'h0, fexp[i]});
    end
    $display("test filter selection finished");
    wr(RS_MODE, 16, {8'h0, MD_SINGLE, 9'h0, 4'hA});
    cnt = 0;
    while (conv_done !== 1'b1 && cnt < 8000) begin
      @(negedge clk_sys);
      cnt++;
    end
    chk(32'(cnt > 2 * PER + OSC - 20 && cnt < 2 * PER + OSC + 20), 32'h1);
    repeat (8) @(negedge clk_sys);
    rd(RS_MODE, 16, v);
    chk(v, {16'h0, MD_PDOWN, 9'h0, 4'hA});
    chk(32'(power_down), 32'h1);
    cnt = 0;
    while (conv_done !== 1'b1 && cnt < 3 * PER) begin
      @(negedge clk_sys);
      cnt++;
    end
    chk(32'(conv_done), 32'h0);
    $display("test single conversion finished");
    xfer(1'b1, 32, 32'h0);
    rd(RS_IO, 8, v);
    chk(v, 32'(IO_RST));
    rd(RS_MODE, 16, v);
    chk(v, 32'(MODE_RST));
    chk({30'h0, filter_sel}, {30'h0, FILT_SINC3_MOD});
    $display("test serial reset finished");
    wrap_up();
  end

  // Run is about 40000 cycles; a hang is cut off well past that
  initial begin
    #(90000 * 20);
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule
